// file: design/dma_seq.sv
// dma sequencer: queues decoder channels and answers the decoder's request events
`timescale 1ns/10ps
`default_nettype none
module dma_seq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [63:0] dma_events,
    output logic             decode_start,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_rd,
    output logic             mem_wr,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic [31:0]      dev_addr,
    output logic [31:0]      dev_wdata,
    output logic             dev_rd,
    output logic             dev_wr,
    input  wire logic [31:0] dev_rdata,
    input  wire logic        dev_ack
);
    // apb and register state
    logic [31:0] flags_ff;
    logic [31:0] cfga_ff;
    logic [31:0] syma_ff;
    logic [31:0] taba_ff;
    logic [31:0] deca_ff;
    logic [31:0] para_ff;
    logic [5:0]  cc_ff;
    logic [5:0]  last_cc_ff;
    logic [3:0]  events_ff;
    logic [7:0]  done_cnt_ff;
    logic        wr_en;
    logic        push_req;
    logic        push_ok;
    logic [3:0]  ev_set;

    // channel table
    logic [31:0] cfg_mem_ff [0:3];
    logic [31:0] sym_mem_ff [0:3];
    logic [31:0] tab_mem_ff [0:3];
    logic [31:0] dec_mem_ff [0:3];
    logic [31:0] par_mem_ff [0:3];
    logic [19:0] flg_mem_ff [0:3];
    logic [2:0]  wr_ptr_ff;
    logic [2:0]  tx_ptr_ff;
    logic [2:0]  rx_ptr_ff;
    logic [1:0]  tx_step_ff;
    logic        rx_step_ff;
    logic [2:0]  queued;

    // request handling and transfer launch
    logic        tx_pend_ff;
    logic        rx_pend_ff;
    logic        busy_ff;
    logic        launch_ff;
    logic [31:0] l_src_ff;
    logic [31:0] l_dst_ff;
    logic [17:0] l_words_ff;
    logic        l_to_dev_ff;
    logic        l_last_ff;
    logic        mv_done;
    logic        tx_evt;
    logic        rx_evt;
    logic        serve_rx;
    logic        serve_tx;

    // per-step choices for the head entries
    logic [31:0] tx_src;
    logic [31:0] tx_dst;
    logic [17:0] tx_words;
    logic        tx_more;
    logic [31:0] rx_src;
    logic [31:0] rx_dst;
    logic [17:0] rx_words;
    logic        rx_more;
    logic [19:0] tx_flg;
    logic [19:0] rx_flg;
    logic [17:0] tx_fl;
    logic [17:0] rx_fl;

    // events come from decoder logic on pclk, so no synchroniser
    assign tx_evt = dma_events[dma_seq_pkg::TX_EVENT_LINE];
    assign rx_evt = dma_events[dma_seq_pkg::RX_EVENT_LINE];

    assign wr_en    = psel && penable && pready && pwrite;
    assign push_req = wr_en && paddr == dma_seq_pkg::OFF_CTRL && pwdata[dma_seq_pkg::CTRL_PUSH];
    assign queued   = wr_ptr_ff - rx_ptr_ff;
    // refuse misaligned buffers, a zero code or a full table
    assign push_ok  = push_req && queued != 3'(dma_seq_pkg::DEPTH)
                      && cfga_ff[2:0] == 3'h0 && syma_ff[2:0] == 3'h0
                      && taba_ff[2:0] == 3'h0 && deca_ff[2:0] == 3'h0
                      && para_ff[2:0] == 3'h0 && cc_ff != 6'h00;

    assign tx_flg = flg_mem_ff[tx_ptr_ff[1:0]];
    assign rx_flg = flg_mem_ff[rx_ptr_ff[1:0]];
    assign tx_fl  = {2'b00, tx_flg[15:0]};
    assign rx_fl  = {2'b00, rx_flg[15:0]};

    // transmit-paced link order of the head channel; all sizes even word counts
    always_comb begin
        tx_src   = cfg_mem_ff[tx_ptr_ff[1:0]];
        tx_dst   = dma_seq_pkg::CFG_WIN;
        tx_words = dma_seq_pkg::CFG_WORDS;
        tx_more  = 1'b1;
        case (tx_step_ff)
            2'd1: begin
                tx_src   = sym_mem_ff[tx_ptr_ff[1:0]];
                tx_dst   = dma_seq_pkg::SYM_WIN;
                tx_words = ((tx_fl + 18'h00001) >> 1) << 1;
                // shared mode always sends apriori unless told to skip it
                tx_more  = tx_flg[dma_seq_pkg::FLG_SP] ? !tx_flg[dma_seq_pkg::FLG_SKIP]
                                                       : tx_flg[dma_seq_pkg::FLG_INTERLEAVER_LOAD_FLAG];
            end
            2'd2: begin
                tx_src   = tab_mem_ff[tx_ptr_ff[1:0]];
                tx_dst   = tx_flg[dma_seq_pkg::FLG_SP] ? dma_seq_pkg::APRIORI_WIN : dma_seq_pkg::INTERLEAVER_LOAD_FLAG_WIN;
                tx_words = tx_flg[dma_seq_pkg::FLG_SP] ? ((tx_fl + 18'h00007) >> 3) << 1
                                                       : ((tx_fl + 18'h00006) >> 2) << 1;
                tx_more  = 1'b0;
            end
            default: begin
                tx_more = 1'b1;
            end
        endcase
    end

    // receive-paced link order of the oldest unfinished channel
    always_comb begin
        rx_dst = dec_mem_ff[rx_ptr_ff[1:0]];
        if (rx_flg[dma_seq_pkg::FLG_SP]) begin
            rx_src   = dma_seq_pkg::EXTR_WIN;
            rx_words = ((rx_fl + 18'h00007) >> 3) << 1;
            rx_more  = 1'b0;
        end else begin
            rx_src   = dma_seq_pkg::HD_WIN;
            rx_words = ((rx_fl + 18'h0003f) >> 6) << 1;
            rx_more  = rx_flg[dma_seq_pkg::FLG_OUTPUT_PARAMS_FLAG];
        end
        if (rx_step_ff) begin
            rx_src   = dma_seq_pkg::OUTP_WIN;
            rx_dst   = par_mem_ff[rx_ptr_ff[1:0]];
            rx_words = dma_seq_pkg::OUTP_WORDS;
            rx_more  = 1'b0;
        end
    end

    assign serve_rx = !busy_ff && !launch_ff && rx_pend_ff;
    assign serve_tx = !busy_ff && !launch_ff && !rx_pend_ff && tx_pend_ff;

    // apb slave: zero-wait answer, ready raised in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= dma_seq_pkg::REG_RESET;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > dma_seq_pkg::OFF_PARA;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    dma_seq_pkg::OFF_CTRL:   prdata <= {18'h00000, cc_ff, 8'h00};
                    dma_seq_pkg::OFF_STATUS: prdata <= {done_cnt_ff, 2'b00, last_cc_ff, 5'h00, queued,
                                                        5'h00, rx_pend_ff, tx_pend_ff, busy_ff};
                    dma_seq_pkg::OFF_EVENTS: prdata <= {28'h0000000, events_ff};
                    dma_seq_pkg::OFF_FLAGS:  prdata <= flags_ff;
                    dma_seq_pkg::OFF_CFGA:   prdata <= cfga_ff;
                    dma_seq_pkg::OFF_SYMA:   prdata <= syma_ff;
                    dma_seq_pkg::OFF_TABA:   prdata <= taba_ff;
                    dma_seq_pkg::OFF_DECA:   prdata <= deca_ff;
                    dma_seq_pkg::OFF_PARA:   prdata <= para_ff;
                    default:                 prdata <= dma_seq_pkg::REG_RESET;
                endcase
            end
        end
    end

    // staging registers for the next channel, and the decode start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff     <= dma_seq_pkg::REG_RESET;
            cfga_ff      <= dma_seq_pkg::REG_RESET;
            syma_ff      <= dma_seq_pkg::REG_RESET;
            taba_ff      <= dma_seq_pkg::REG_RESET;
            deca_ff      <= dma_seq_pkg::REG_RESET;
            para_ff      <= dma_seq_pkg::REG_RESET;
            cc_ff        <= 6'h00;
            decode_start <= 1'b0;
        end else begin
            decode_start <= wr_en && paddr == dma_seq_pkg::OFF_CTRL && pwdata[dma_seq_pkg::CTRL_START];
            if (wr_en) begin
                case (paddr)
                    dma_seq_pkg::OFF_CTRL:  cc_ff    <= pwdata[dma_seq_pkg::CC_LSB +: dma_seq_pkg::CC_W];
                    dma_seq_pkg::OFF_FLAGS: flags_ff <= {12'h000, pwdata[19:0]};
                    dma_seq_pkg::OFF_CFGA:  cfga_ff  <= pwdata;
                    dma_seq_pkg::OFF_SYMA:  syma_ff  <= pwdata;
                    dma_seq_pkg::OFF_TABA:  taba_ff  <= pwdata;
                    dma_seq_pkg::OFF_DECA:  deca_ff  <= pwdata;
                    dma_seq_pkg::OFF_PARA:  para_ff  <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // channel table: many channels may be queued before decoding starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= 3'h0;
            for (int i = 0; i < dma_seq_pkg::DEPTH; i++) begin
                cfg_mem_ff[i] <= dma_seq_pkg::REG_RESET;
                sym_mem_ff[i] <= dma_seq_pkg::REG_RESET;
                tab_mem_ff[i] <= dma_seq_pkg::REG_RESET;
                dec_mem_ff[i] <= dma_seq_pkg::REG_RESET;
                par_mem_ff[i] <= dma_seq_pkg::REG_RESET;
                flg_mem_ff[i] <= 20'h00000;
            end
        end else if (push_ok) begin
            cfg_mem_ff[wr_ptr_ff[1:0]] <= cfga_ff;
            sym_mem_ff[wr_ptr_ff[1:0]] <= syma_ff;
            tab_mem_ff[wr_ptr_ff[1:0]] <= taba_ff;
            dec_mem_ff[wr_ptr_ff[1:0]] <= deca_ff;
            par_mem_ff[wr_ptr_ff[1:0]] <= para_ff;
            flg_mem_ff[wr_ptr_ff[1:0]] <= flags_ff[19:0];
            wr_ptr_ff <= wr_ptr_ff + 3'h1;
        end
    end

    // pending requests: a new event wins over the clear that serves the old one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend_ff <= 1'b0;
            rx_pend_ff <= 1'b0;
        end else begin
            tx_pend_ff <= tx_evt || (tx_pend_ff && !serve_tx);
            rx_pend_ff <= rx_evt || (rx_pend_ff && !serve_rx);
        end
    end

    // one linked transfer per request; reads take priority over writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff     <= 1'b0;
            launch_ff   <= 1'b0;
            l_src_ff    <= dma_seq_pkg::REG_RESET;
            l_dst_ff    <= dma_seq_pkg::REG_RESET;
            l_words_ff  <= 18'h00000;
            l_to_dev_ff <= 1'b0;
            l_last_ff   <= 1'b0;
            tx_ptr_ff   <= 3'h0;
            rx_ptr_ff   <= 3'h0;
            tx_step_ff  <= 2'd0;
            rx_step_ff  <= 1'b0;
        end else begin
            launch_ff <= 1'b0;
            if (mv_done) begin
                busy_ff <= 1'b0;
                if (l_last_ff) begin
                    rx_ptr_ff <= rx_ptr_ff + 3'h1;
                end
            end
            if (serve_rx && rx_ptr_ff != tx_ptr_ff) begin
                busy_ff     <= 1'b1;
                launch_ff   <= 1'b1;
                l_src_ff    <= rx_src;
                l_dst_ff    <= rx_dst;
                l_words_ff  <= rx_words;
                l_to_dev_ff <= 1'b0;
                l_last_ff   <= !rx_more;
                rx_step_ff  <= rx_more;
            end else if (serve_tx && tx_ptr_ff != wr_ptr_ff) begin
                busy_ff     <= 1'b1;
                launch_ff   <= 1'b1;
                l_src_ff    <= tx_src;
                l_dst_ff    <= tx_dst;
                l_words_ff  <= tx_words;
                l_to_dev_ff <= 1'b1;
                l_last_ff   <= 1'b0;
                tx_step_ff  <= tx_more ? tx_step_ff + 2'd1 : 2'd0;
                if (!tx_more) begin
                    tx_ptr_ff <= tx_ptr_ff + 3'h1;
                end
            end
        end
    end

    // sticky software notifications, write one to clear; a new set wins
    assign ev_set[dma_seq_pkg::EV_DONE]   = mv_done && l_last_ff;
    assign ev_set[dma_seq_pkg::EV_REFUSE] = push_req && !push_ok;
    assign ev_set[dma_seq_pkg::EV_NULLRX] = serve_rx && rx_ptr_ff == tx_ptr_ff;
    assign ev_set[dma_seq_pkg::EV_DUMMY]  = serve_tx && tx_ptr_ff == wr_ptr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events_ff   <= 4'h0;
            done_cnt_ff <= 8'h00;
            last_cc_ff  <= 6'h00;
        end else begin
            if (wr_en && paddr == dma_seq_pkg::OFF_EVENTS) begin
                events_ff <= (events_ff & ~pwdata[3:0]) | ev_set;
            end else begin
                events_ff <= events_ff | ev_set;
            end
            if (ev_set[dma_seq_pkg::EV_DONE]) begin
                done_cnt_ff <= done_cnt_ff + 8'h01;
            end
            if (mv_done) begin
                last_cc_ff <= cc_ff;
            end
        end
    end

    word_mover u_mover (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (launch_ff),
        .src       (l_src_ff),
        .dst       (l_dst_ff),
        .words     (l_words_ff),
        .to_dev    (l_to_dev_ff),
        .done      (mv_done),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .mem_rdata (mem_rdata),
        .mem_ack   (mem_ack),
        .dev_addr  (dev_addr),
        .dev_wdata (dev_wdata),
        .dev_rd    (dev_rd),
        .dev_wr    (dev_wr),
        .dev_rdata (dev_rdata),
        .dev_ack   (dev_ack)
    );
endmodule
`default_nettype wire

// file: design/dma_seq_pkg.sv
// constants shared by the turbo-decoder dma sequencer and its word mover
// Behaviour
// - standalone channel: three to five linked transfers
// - shared channel: config, symbols, apriori, extrinsics
// - queue several channels, serve them in order
// - receive request on line 30 paces reads
// - transmit request on line 31 paces writes
// - transfer byte counts multiple of eight, except the 12-byte output params
// - config: 64 bytes to window base
// - memory buffers start double-word aligned
// - symbols: eight times ceil(frame/2) bytes
// - config transfer links to symbol transfer
// - symbols link to interleaver when flagged
// - otherwise symbols link to next channel config
// - no channel left: dummy transfer, never null; here no transfer is launched, only EV_DUMMY (tx) or EV_NULLRX (rx) is set
// - notify software after channel's last read
// - completion code 1..63, no chaining, no irq
// - incrementing addresses, zero dimension indices
// - decisions: eight times ceil(frame/64) bytes
// - interleaver: eight times ceil((frame+3)/4) bytes
// - output params: 12 bytes when flagged
package dma_seq_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int FL_W   = 16;
    localparam int CNT_W  = 18;
    localparam int DEPTH  = 4;
    localparam int PTR_W  = 2;
    localparam int EVT_W  = 64;

    // dma event line numbers
    localparam int RX_EVENT_LINE = 30;
    localparam int TX_EVENT_LINE = 31;

    // device windows
    localparam logic [31:0] CFG_WIN     = 32'h5000_0000;
    localparam logic [31:0] SYM_WIN     = 32'h5001_0000;
    localparam logic [31:0] INTERLEAVER_LOAD_FLAG_WIN   = 32'h5005_0000;
    localparam logic [31:0] HD_WIN      = 32'h5006_0000;
    localparam logic [31:0] OUTP_WIN    = 32'h5000_0030;
    localparam logic [31:0] APRIORI_WIN = 32'h5002_0000;
    localparam logic [31:0] EXTR_WIN    = 32'h5003_0000;

    // transfer sizes in 32-bit words, and the byte address step per word
    localparam logic [17:0] CFG_WORDS  = 18'h00010;
    localparam logic [17:0] OUTP_WORDS = 18'h00003;
    localparam logic [31:0] WORD_STEP  = 32'h0000_0004;

    // own register map
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_EVENTS = 8'h08;
    localparam logic [7:0] OFF_FLAGS  = 8'h0c;
    localparam logic [7:0] OFF_CFGA   = 8'h10;
    localparam logic [7:0] OFF_SYMA   = 8'h14;
    localparam logic [7:0] OFF_TABA   = 8'h18;
    localparam logic [7:0] OFF_DECA   = 8'h1c;
    localparam logic [7:0] OFF_PARA   = 8'h20;

    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_PUSH  = 1;
    localparam int CC_LSB     = 8;
    localparam int CC_W       = 6;

    // channel flag fields
    localparam int FLG_INTERLEAVER_LOAD_FLAG = 16;
    localparam int FLG_OUTPUT_PARAMS_FLAG  = 17;
    localparam int FLG_SP    = 18;
    localparam int FLG_SKIP  = 19;

    // sticky event bits
    localparam int EV_DONE   = 0;
    localparam int EV_REFUSE = 1;
    localparam int EV_NULLRX = 2;
    localparam int EV_DUMMY  = 3;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// file: design/word_mover.sv
// word mover: copies a run of 32-bit words between memory and device
`timescale 1ns/10ps
`default_nettype none
module word_mover (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] src,
    input  wire logic [31:0] dst,
    input  wire logic [17:0] words,
    input  wire logic        to_dev,
    output logic             done,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_rd,
    output logic             mem_wr,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic [31:0]      dev_addr,
    output logic [31:0]      dev_wdata,
    output logic             dev_rd,
    output logic             dev_wr,
    input  wire logic [31:0] dev_rdata,
    input  wire logic        dev_ack
);
    typedef enum logic [1:0] {MV_IDLE, MV_READ, MV_WRITE} mv_state_t;

    mv_state_t   state_ff;
    logic [31:0] src_ff;
    logic [31:0] dst_ff;
    logic [17:0] left_ff;
    logic        to_dev_ff;
    logic        src_ack;
    logic        dst_ack;
    logic [31:0] src_data;

    assign src_ack  = to_dev_ff ? mem_ack : dev_ack;
    assign dst_ack  = to_dev_ff ? dev_ack : mem_ack;
    assign src_data = to_dev_ff ? mem_rdata : dev_rdata;

    // one word at a time: read source, then write destination, both incrementing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= MV_IDLE;
            src_ff    <= 32'h0000_0000;
            dst_ff    <= 32'h0000_0000;
            left_ff   <= 18'h00000;
            to_dev_ff <= 1'b0;
            done      <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            dev_addr  <= 32'h0000_0000;
            dev_wdata <= 32'h0000_0000;
            dev_rd    <= 1'b0;
            dev_wr    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_ff)
                MV_IDLE: begin
                    if (start && words == 18'h00000) begin
                        done <= 1'b1;
                    end else if (start) begin
                        src_ff    <= src;
                        dst_ff    <= dst;
                        left_ff   <= words;
                        to_dev_ff <= to_dev;
                        state_ff  <= MV_READ;
                        if (to_dev) begin
                            mem_addr <= src;
                            mem_rd   <= 1'b1;
                        end else begin
                            dev_addr <= src;
                            dev_rd   <= 1'b1;
                        end
                    end
                end
                MV_READ: begin
                    if (src_ack) begin
                        mem_rd   <= 1'b0;
                        dev_rd   <= 1'b0;
                        state_ff <= MV_WRITE;
                        if (to_dev_ff) begin
                            dev_addr  <= dst_ff;
                            dev_wdata <= src_data;
                            dev_wr    <= 1'b1;
                        end else begin
                            mem_addr  <= dst_ff;
                            mem_wdata <= src_data;
                            mem_wr    <= 1'b1;
                        end
                    end
                end
                MV_WRITE: begin
                    if (dst_ack) begin
                        mem_wr  <= 1'b0;
                        dev_wr  <= 1'b0;
                        left_ff <= left_ff - 18'h00001;
                        src_ff  <= src_ff + dma_seq_pkg::WORD_STEP;
                        dst_ff  <= dst_ff + dma_seq_pkg::WORD_STEP;
                        if (left_ff == 18'h00001) begin
                            done     <= 1'b1;
                            state_ff <= MV_IDLE;
                        end else begin
                            state_ff <= MV_READ;
                            if (to_dev_ff) begin
                                mem_addr <= src_ff + dma_seq_pkg::WORD_STEP;
                                mem_rd   <= 1'b1;
                            end else begin
                                dev_addr <= src_ff + dma_seq_pkg::WORD_STEP;
                                dev_rd   <= 1'b1;
                            end
                        end
                    end
                end
                default: state_ff <= MV_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/dec_model.sv
// decoder model: window port, config words and request events
`timescale 1ns/10ps
`default_nettype none
module dec_model (
    input wire logic [31:0] dev_addr,
    input wire logic [31:0] dev_wdata,
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        dev_rd,
    input wire logic        dev_wr,
    input wire logic        decode_start,
    input wire logic        kick_tx,
    input wire logic        kick_rx,
    output logic [31:0]     dev_rdata,
    output logic            dev_ack,
    output logic [63:0]     dma_events
);
    logic [31:0] cfg_mem [16];
    int          wr_cnt;
    int          rd_cnt;
    logic        slow_ff;
    // answers alternate between quick and slow; released bus toggles so stale data never matches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_ff <= 1'b0;
            dev_ack <= 1'b0;
            dev_rdata <= 32'h0;
            wr_cnt <= 0;
            rd_cnt <= 0;
        end else begin
            slow_ff <= !slow_ff;
            dev_ack <= (dev_rd || dev_wr) && !dev_ack && slow_ff;
            dev_rdata <= dev_rd ? ~dev_addr : ~dev_rdata;
            if (dev_wr && dev_ack) wr_cnt <= wr_cnt + 1;
            if (dev_rd && dev_ack) rd_cnt <= rd_cnt + 1;
        end
    end
    // configuration words land in the config window
    always_ff @(posedge pclk) begin
        if (dev_wr && dev_ack && dev_addr[31:16] == 16'h5000) cfg_mem[dev_addr[5:2]] <= dev_wdata;
    end
    // one-cycle pulses; tx on line 31, rx on line 30
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dma_events <= 64'h0;
        else dma_events <= {32'h0, decode_start | kick_tx, kick_rx, 30'h0};
    end
endmodule
`default_nettype wire

// file: tb/dma_seq_bench.sv
// self-checking bench for the dma sequencer
`timescale 1ns/10ps
`default_nettype none
module dma_seq_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata = 32'h0, dev_addr, dev_wdata, dev_rdata;
    logic pready, pslverr, decode_start, mem_rd, mem_wr, mem_ack = 1'b0, dev_rd, dev_wr, dev_ack;
    logic kick_tx = 1'b0, kick_rx = 1'b0, err;
    logic [63:0] dma_events;
    logic [31:0] rd, last_addr = 32'h0, last_wdata = 32'h0;
    int num_errors = 0, compares = 0;
    dma_seq u_dma_seq (.*);
    dec_model u_dec_model (.*);
    always #20 pclk = ~pclk;
    // processor memory: data is the address xor a pattern
    always_ff @(posedge pclk) begin
        mem_ack <= (mem_rd || mem_wr) && !mem_ack;
        mem_rdata <= mem_rd ? mem_addr ^ 32'h5a5a_0000 : ~mem_rdata;
        if (mem_ack) last_addr <= mem_addr;
        if (mem_ack && mem_wr) last_wdata <= mem_wdata;
    end
    task wrap_up;
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // pready taken at a rising edge; an idle edge parts two calls
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (n == 20) begin num_errors++; wrap_up; end
    endtask
    task poll(input logic [7:0] a, input logic [31:0] m);
        int n;
        n = 0; rd = 32'h0;
        while ((rd & m) !== m && n < 100) begin apb(1'b0, a, 32'h0); n++; end
        check(rd & m, m);
        if (n == 100) wrap_up;
    endtask
    task kick(input bit rx_side);
        if (rx_side) kick_rx <= 1'b1; else kick_tx <= 1'b1;
        @(posedge pclk);
        kick_rx <= 1'b0; kick_tx <= 1'b0;
    endtask
    task wait_cnt(input bit rx_side, input int want);
        int n;
        n = 0;
        while ((rx_side ? u_dec_model.rd_cnt : u_dec_model.wr_cnt) != want && n < 900) begin @(posedge pclk); n++; end
        if (n == 900) begin num_errors++; wrap_up; end
    endtask
    task t_null;
        kick(1'b1);
        poll(8'h08, 32'h4);
    endtask
    task t_refuse;
        apb(1'b1, 8'h00, 32'h0000_0002);
        poll(8'h08, 32'h2);
        apb(1'b1, 8'h08, 32'h0000_000f);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task t_channel;
        apb(1'b1, 8'h0c, 32'h0001_0002);
        apb(1'b1, 8'h10, 32'h0000_0100);
        apb(1'b1, 8'h14, 32'h0000_0200);
        apb(1'b1, 8'h1c, 32'h0000_0300);
        apb(1'b1, 8'h00, 32'h0000_0500);
        apb(1'b1, 8'h00, 32'h0000_0503);
        wait_cnt(1'b0, 16);
        check(u_dec_model.cfg_mem[0], 32'h5a5a_0100);
        check(u_dec_model.cfg_mem[15], 32'h5a5a_013c);
        kick(1'b0);
        wait_cnt(1'b0, 18);
        check(last_addr, 32'h0000_0204);
        kick(1'b0);
        wait_cnt(1'b0, 22);
        kick(1'b1);
        poll(8'h08, 32'h1);
        check(last_addr, 32'h0000_0304);
        check(last_wdata, ~32'h5006_0004);
        check(u_dec_model.wr_cnt, 32'd22);
        apb(1'b0, 8'h04, 32'h0);
        check({8'h0, rd[31:24], 10'h0, rd[21:16]}, 32'h0001_0005);
        kick(1'b0);
        poll(8'h08, 32'h8);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_null;
        t_refuse;
        t_channel;
        wrap_up;
    end
endmodule
bind dma_seq seq_chk u_seq_chk (.*);
`default_nettype wire

// file: tb/seq_chk_asserts.sv
// concurrent checks on the sequencer's apb and transfer ports
`timescale 1ns/10ps
`default_nettype none
module seq_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        decode_start,
    input wire logic        mem_rd,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_ack,
    input wire logic [31:0] dev_addr,
    input wire logic [31:0] dev_wdata,
    input wire logic        dev_rd,
    input wire logic        dev_wr,
    input wire logic        dev_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_follows: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h20)) else $error("bad slave error");
    a_start_pulse: assert property (decode_start |=> !decode_start) else $error("start not a pulse");
    a_dev_hold: assert property ((dev_wr || dev_rd) && !dev_ack |=> (dev_wr || dev_rd)
        && $stable(dev_addr) && $stable(dev_wdata)) else $error("device request dropped early");
    a_mem_hold: assert property (mem_rd && !mem_ack |=> mem_rd) else $error("memory read dropped early");
    a_word_pass: assert property (mem_rd && mem_ack |=> dev_wr && dev_wdata == $past(mem_rdata))
        else $error("word not passed on");
    a_dev_window: assert property (dev_wr || dev_rd |-> dev_addr[31:24] == 8'h50 && dev_addr[1:0] == 2'b00)
        else $error("device address outside windows");
endmodule
`default_nettype wire
